// [rtl/adc_pkg.sv]
// shared constants and types for the converter output capture block
package adc_pkg;

    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int RESULT_W = 15;
    localparam int ANALOG_W = 16;
    localparam int DIFF_W = 17;
    localparam int FIFO_W = 32;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;

    // ------------------------------------------------------------
    // pipeline and timing
    // ------------------------------------------------------------
    localparam int PIPE_LATENCY = 3;
    localparam real CLK_SYS_NS = 4.0;
    // nominal falling-edge to strobe delay; the strobe here rises on the
    // falling edge itself, the analog driver delay is not modelled
    localparam real STROBE_DELAY_NS = 6.5;
    localparam int STROBE_DELAY_CYC =
        (STROBE_DELAY_NS / CLK_SYS_NS) < 1.0 ? 1 :
        int'($floor(STROBE_DELAY_NS / CLK_SYS_NS));

    // ------------------------------------------------------------
    // code limits, two's complement full scale
    // ------------------------------------------------------------
    localparam logic signed [16:0] CODE_MAX = 17'sh0_3FFF;
    localparam logic signed [16:0] CODE_MIN = -17'sh0_4000;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [14:0] RESULT_RST = 15'h0000;
    localparam logic [15:0] ANALOG_RST = 16'h0000;
    localparam logic [2:0] PTR_RST = 3'h0;
    localparam logic [3:0] CNT_RST = 4'h0;

    // ------------------------------------------------------------
    // transfer state machine, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        XFER_IDLE = 2'b01,
        XFER_WAIT = 2'b10
    } xfer_state_t;

endpackage

// [rtl/sample_fifo.sv]
// synchronous fifo with registered read data, valid/ready on both sides
module sample_fifo #(
    parameter int WIDTH = adc_pkg::FIFO_W,
    parameter int DEPTH = adc_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
    logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
    logic [AW:0] count_ff, nxt_count;
    logic out_valid_ff, nxt_out_valid;
    logic [WIDTH-1:0] out_data_ff, nxt_out_data;
    logic push;
    logic load;

    // ------------------------------------------------------------
    // control
    // ------------------------------------------------------------
    // load the output register when it is empty or being drained
    always_comb begin
        o_in_ready = (count_ff != DEPTH_C);
        push = i_in_valid && o_in_ready;
        load = (count_ff != '0) && (!out_valid_ff || i_out_ready);
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = load ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_count = count_ff + (AW + 1)'(push) - (AW + 1)'(load);
        nxt_out_data = load ? mem_ff[rd_ptr_ff] : out_data_ff;
        if (load) begin
            nxt_out_valid = 1'b1;
        end else if (i_out_ready) begin
            nxt_out_valid = 1'b0;
        end else begin
            nxt_out_valid = out_valid_ff;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            out_valid_ff <= nxt_out_valid;
            out_data_ff <= nxt_out_data;
        end
    end

    // storage carries no reset
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end

    assign o_out_valid = out_valid_ff;
    assign o_out_data = out_data_ff;

endmodule

// [rtl/adc_parallel_output_capture.sv]
// converter digital output: sampling, pipeline, result bus and strobe
module adc_parallel_output_capture (
    // system clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // analog stream in, system domain
    input wire logic i_analog_valid,
    input wire logic [15:0] i_analog_in_pos,
    input wire logic [15:0] i_analog_in_neg,
    output logic o_analog_ready,
    // differential sample clock
    input wire logic i_sample_clock_pos,
    input wire logic i_sample_clock_neg,
    // parallel result outputs
    output logic [14:0] o_result_bus,
    output logic o_overrange_flag,
    output logic o_result_valid_strobe,
    output logic o_clock_pair_fault
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic signed [16:0] diff_code(
        input logic [15:0] pos,
        input logic [15:0] neg
    );
        diff_code = 17'($signed(pos)) - 17'($signed(neg));
    endfunction

    function automatic logic out_of_range(input logic signed [16:0] d);
        out_of_range = (d > adc_pkg::CODE_MAX) || (d < adc_pkg::CODE_MIN);
    endfunction

    function automatic logic [14:0] clamp_code(input logic signed [16:0] d);
        if (d > adc_pkg::CODE_MAX) begin
            clamp_code = adc_pkg::CODE_MAX[14:0];
        end else if (d < adc_pkg::CODE_MIN) begin
            clamp_code = adc_pkg::CODE_MIN[14:0];
        end else begin
            clamp_code = d[14:0];
        end
    endfunction

    // a toggle request is open while the two sides disagree
    function automatic logic toggle_open(input logic req, input logic ack);
        toggle_open = (req != ack);
    endfunction

    // ------------------------------------------------------------
    // input buffering, system domain
    // ------------------------------------------------------------
    logic fifo_valid;
    logic [31:0] fifo_data;
    logic fifo_ready;
    // positive leg rides in the upper half of the fifo word
    logic [15:0] fifo_pos;
    logic [15:0] fifo_neg;

    sample_fifo #(
        .WIDTH(adc_pkg::FIFO_W),
        .DEPTH(adc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_in_valid(i_analog_valid),
        .i_in_data({i_analog_in_pos, i_analog_in_neg}),
        .o_in_ready(o_analog_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(fifo_ready)
    );

    assign fifo_pos = fifo_data[31:16];
    assign fifo_neg = fifo_data[15:0];

    // ------------------------------------------------------------
    // word crossing to the sample clock, toggle handshake
    // ------------------------------------------------------------
    // the held word only changes while req and ack agree, so the link
    // side never sees it move while it copies it
    adc_pkg::xfer_state_t state_ff, nxt_state;
    logic req_ff, nxt_req;
    logic [15:0] xfer_pos_ff, nxt_xfer_pos;
    logic [15:0] xfer_neg_ff, nxt_xfer_neg;
    logic ack_s1_ff, ack_s2_ff;
    // ack_ff belongs to the sample clock; only ack_s1_ff may read it
    logic ack_ff, nxt_ack;
    logic ack_seen;

    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_xfer_pos = xfer_pos_ff;
        nxt_xfer_neg = xfer_neg_ff;
        fifo_ready = 1'b0;
        case (state_ff)
            adc_pkg::XFER_IDLE: begin
                fifo_ready = 1'b1;
                if (fifo_valid) begin
                    nxt_xfer_pos = fifo_pos;
                    nxt_xfer_neg = fifo_neg;
                    nxt_req = ~req_ff;
                    nxt_state = adc_pkg::XFER_WAIT;
                end
            end
            adc_pkg::XFER_WAIT: begin
                if (ack_seen) begin
                    nxt_state = adc_pkg::XFER_IDLE;
                end
            end
            default: begin
                nxt_state = adc_pkg::XFER_IDLE;
            end
        endcase
    end

    assign ack_seen = !toggle_open(req_ff, ack_s2_ff);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= adc_pkg::XFER_IDLE;
            req_ff <= 1'b0;
            xfer_pos_ff <= adc_pkg::ANALOG_RST;
            xfer_neg_ff <= adc_pkg::ANALOG_RST;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            xfer_pos_ff <= nxt_xfer_pos;
            xfer_neg_ff <= nxt_xfer_neg;
            ack_s1_ff <= ack_ff;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // sample clock domain reset
    // ------------------------------------------------------------
    // asserted at once, released on the sample clock
    logic lrst_a_ff, lrst_b_ff;
    logic lrst_n;

    always_ff @(posedge i_sample_clock_pos or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lrst_a_ff <= 1'b0;
            lrst_b_ff <= 1'b0;
        end else begin
            lrst_a_ff <= 1'b1;
            lrst_b_ff <= lrst_a_ff;
        end
    end

    assign lrst_n = lrst_b_ff;

    // ------------------------------------------------------------
    // track and hold plus conversion pipeline, sample clock domain
    // ------------------------------------------------------------
    logic req_s1_ff, req_s2_ff;
    logic [15:0] held_pos_ff, nxt_held_pos;
    logic [15:0] held_neg_ff, nxt_held_neg;
    logic signed [16:0] held_diff;
    logic [14:0] stg_code_ff [adc_pkg::PIPE_LATENCY];
    logic [14:0] nxt_stg_code [adc_pkg::PIPE_LATENCY];
    logic stg_or_ff [adc_pkg::PIPE_LATENCY];
    logic nxt_stg_or [adc_pkg::PIPE_LATENCY];
    logic stg_vld_ff [adc_pkg::PIPE_LATENCY];
    logic nxt_stg_vld [adc_pkg::PIPE_LATENCY];
    logic [14:0] result_ff, nxt_result;
    logic overrange_ff, nxt_overrange;
    logic out_vld_ff, nxt_out_vld;

    always_comb begin
        held_diff = diff_code(held_pos_ff, held_neg_ff);
        nxt_ack = ack_ff;
        nxt_held_pos = held_pos_ff;
        nxt_held_neg = held_neg_ff;
        if (toggle_open(req_s2_ff, ack_ff)) begin
            nxt_held_pos = xfer_pos_ff;
            nxt_held_neg = xfer_neg_ff;
            nxt_ack = req_s2_ff;
        end
        // every rising edge takes the held input, one per period
        nxt_stg_code[0] = clamp_code(held_diff);
        nxt_stg_or[0] = out_of_range(held_diff);
        nxt_stg_vld[0] = 1'b1;
        for (int i = 1; i < adc_pkg::PIPE_LATENCY; i++) begin
            nxt_stg_code[i] = stg_code_ff[i-1];
            nxt_stg_or[i] = stg_or_ff[i-1];
            nxt_stg_vld[i] = stg_vld_ff[i-1];
        end
        nxt_result = stg_code_ff[adc_pkg::PIPE_LATENCY-1];
        nxt_overrange = stg_or_ff[adc_pkg::PIPE_LATENCY-1];
        nxt_out_vld = stg_vld_ff[adc_pkg::PIPE_LATENCY-1];
    end

    always_ff @(posedge i_sample_clock_pos or negedge lrst_n) begin
        if (!lrst_n) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            ack_ff <= 1'b0;
            held_pos_ff <= adc_pkg::ANALOG_RST;
            held_neg_ff <= adc_pkg::ANALOG_RST;
            for (int i = 0; i < adc_pkg::PIPE_LATENCY; i++) begin
                stg_code_ff[i] <= adc_pkg::RESULT_RST;
                stg_or_ff[i] <= 1'b0;
                stg_vld_ff[i] <= 1'b0;
            end
            result_ff <= adc_pkg::RESULT_RST;
            overrange_ff <= 1'b0;
            out_vld_ff <= 1'b0;
        end else begin
            req_s1_ff <= req_ff;
            req_s2_ff <= req_s1_ff;
            ack_ff <= nxt_ack;
            held_pos_ff <= nxt_held_pos;
            held_neg_ff <= nxt_held_neg;
            for (int i = 0; i < adc_pkg::PIPE_LATENCY; i++) begin
                stg_code_ff[i] <= nxt_stg_code[i];
                stg_or_ff[i] <= nxt_stg_or[i];
                stg_vld_ff[i] <= nxt_stg_vld[i];
            end
            result_ff <= nxt_result;
            overrange_ff <= nxt_overrange;
            out_vld_ff <= nxt_out_vld;
        end
    end

    // bit 0 is the lsb, bit 14 the sign
    assign o_result_bus = result_ff;
    assign o_overrange_flag = overrange_ff;

    // ------------------------------------------------------------
    // valid strobe: high from falling edge to next rising edge
    // ------------------------------------------------------------
    // data moves on the rising edge, so the strobe rising edge lands
    // half a period later in the middle of the stable data window
    // limitation: the analog driver delay after the falling edge is not
    // modelled, so this strobe leads a real pin by that delay
    logic dav_neg_ff, nxt_dav_neg;
    logic dav_pos_ff, nxt_dav_pos;

    always_comb begin
        nxt_dav_neg = out_vld_ff ? ~dav_pos_ff : dav_pos_ff;
        nxt_dav_pos = dav_neg_ff;
    end

    always_ff @(negedge i_sample_clock_pos or negedge lrst_n) begin
        if (!lrst_n) begin
            dav_neg_ff <= 1'b0;
        end else begin
            dav_neg_ff <= nxt_dav_neg;
        end
    end

    always_ff @(posedge i_sample_clock_pos or negedge lrst_n) begin
        if (!lrst_n) begin
            dav_pos_ff <= 1'b0;
        end else begin
            dav_pos_ff <= nxt_dav_pos;
        end
    end

    // one pulse per period; usable as a latch clock downstream
    assign o_result_valid_strobe = dav_neg_ff ^ dav_pos_ff;

    // ------------------------------------------------------------
    // clock pair check
    // ------------------------------------------------------------
    // the negative leg should be low at each rising edge of the positive
    // a level, not sticky: it clears once the pair is healthy again
    logic neg_s1_ff, neg_s2_ff;
    logic fault_ff, nxt_fault;

    always_comb begin
        nxt_fault = neg_s2_ff;
    end

    always_ff @(posedge i_sample_clock_pos or negedge lrst_n) begin
        if (!lrst_n) begin
            neg_s1_ff <= 1'b0;
            neg_s2_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            neg_s1_ff <= i_sample_clock_neg;
            neg_s2_ff <= neg_s1_ff;
            fault_ff <= nxt_fault;
        end
    end

    assign o_clock_pair_fault = fault_ff;

endmodule

// [verif/adc_capture_chk.sv]
// assertion checker for the converter output capture block
module adc_capture_chk (
    // clocks and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_sample_clock_pos,
    // input stream
    input wire logic i_analog_valid,
    input wire logic o_analog_ready,
    // result outputs
    input wire logic [14:0] o_result_bus,
    input wire logic o_overrange_flag,
    input wire logic o_result_valid_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    // saturating, ready may only drop once eight words went in
    logic [3:0] push_cnt_ff;
    logic [3:0] nxt_push_cnt;
    always_comb begin
        nxt_push_cnt = push_cnt_ff;
        if (i_analog_valid && o_analog_ready && push_cnt_ff != 4'hF) begin
            nxt_push_cnt = push_cnt_ff + 4'h1;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            push_cnt_ff <= 4'h0;
        end else begin
            push_cnt_ff <= nxt_push_cnt;
        end
    end
    a_ready_needs_fill: assert property (@(posedge i_clk_sys)
        disable iff (!i_arst_n) (push_cnt_ff < 4'h8) |-> o_analog_ready)
        else $error("input ready dropped before eight words");
    a_clamp_high: assert property (@(posedge i_sample_clock_pos)
        disable iff (!i_arst_n) o_overrange_flag && !o_result_bus[14]
        |-> o_result_bus == 15'h3FFF) else $error("high overrange not full");
    a_clamp_low: assert property (@(posedge i_sample_clock_pos)
        disable iff (!i_arst_n) o_overrange_flag && o_result_bus[14]
        |-> o_result_bus == 15'h4000) else $error("low overrange not full");
    a_strobe_low_phase: assert property (@(negedge i_sample_clock_pos)
        disable iff (!i_arst_n) !o_result_valid_strobe)
        else $error("strobe high during clock high phase");
    a_strobe_steady: assert property (@(posedge i_sample_clock_pos)
        disable iff (!i_arst_n) $past(o_result_valid_strobe)
        |-> o_result_valid_strobe) else $error("strobe pulse missed");
    a_strobe_fill_wait: assert property (@(posedge i_sample_clock_pos)
        disable iff (!i_arst_n) $rose(o_result_valid_strobe)
        |-> $past(i_arst_n, 4)) else $error("strobe before pipeline full");
    a_result_reset_zero: assert property (@(posedge i_sample_clock_pos)
        disable iff (!i_arst_n) $past(i_arst_n) == 1'b0
        |-> o_result_bus == 15'h0000 && !o_overrange_flag
        && !o_result_valid_strobe) else $error("output left reset early");
    c_strobe: cover property (@(posedge i_sample_clock_pos)
        $rose(o_result_valid_strobe));
    c_overrange: cover property (@(posedge i_sample_clock_pos)
        o_overrange_flag);
    c_full: cover property (@(posedge i_clk_sys) !o_analog_ready);
endmodule

bind adc_parallel_output_capture adc_capture_chk u_adc_capture_chk (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_sample_clock_pos(i_sample_clock_pos),
    .i_analog_valid(i_analog_valid),
    .o_analog_ready(o_analog_ready),
    .o_result_bus(o_result_bus),
    .o_overrange_flag(o_overrange_flag),
    .o_result_valid_strobe(o_result_valid_strobe)
);

// [verif/capture_latch_model.sv]
// capture latch model clocked by the converter valid strobe
module capture_latch_model (
    // strobe and data from the converter
    input wire logic i_strobe,
    input wire logic [14:0] i_word,
    input wire logic i_flag,
    // last captured record
    output logic [14:0] o_word,
    output logic o_flag,
    output int o_count
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_word = 15'h0000;
        o_flag = 1'b0;
        o_count = 0;
    end
    // word and flag land together as one record
    always @(posedge i_strobe) begin
        o_word <= i_word;
        o_flag <= i_flag;
        o_count <= o_count + 1;
    end
endmodule

// [verif/testbench.sv]
// self-checking bench for the converter output capture block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic clk_smp = 1'b0;
    logic arst_n = 1'b0;
    logic in_valid = 1'b0;
    logic [15:0] in_pos = 16'h0000;
    logic [15:0] in_neg = 16'h0000;
    logic clk_smp_n = 1'b1;
    logic pair_ok = 1'b1;
    logic smp_neg, pair_fault;
    logic ready, flag, strobe, cap_flag;
    logic [14:0] res, cap_word;
    int cap_count;
    int stalls = 0;
    int miscompares = 0;
    int n_compared = 0;
    always #2 clk_sys = ~clk_sys;
    always #3 clk_smp = ~clk_smp;
    // the negative leg leads by half a nanosecond, so the pair check
    // never samples it in the time step of its own transition
    initial begin
        #2.5;
        forever begin
            clk_smp_n = ~clk_smp_n;
            #3;
        end
    end
    // pair_ok low parks the negative leg high to provoke a pair fault
    assign smp_neg = pair_ok ? clk_smp_n : 1'b1;
    adc_parallel_output_capture u_adc_parallel_output_capture (
        .i_clk_sys(clk_sys),
        .i_arst_n(arst_n),
        .i_analog_valid(in_valid),
        .i_analog_in_pos(in_pos),
        .i_analog_in_neg(in_neg),
        .o_analog_ready(ready),
        .i_sample_clock_pos(clk_smp),
        .i_sample_clock_neg(smp_neg),
        .o_result_bus(res),
        .o_overrange_flag(flag),
        .o_result_valid_strobe(strobe),
        .o_clock_pair_fault(pair_fault)
    );
    capture_latch_model u_capture_latch_model (
        .i_strobe(strobe),
        .i_word(res),
        .i_flag(flag),
        .o_word(cap_word),
        .o_flag(cap_flag),
        .o_count(cap_count)
    );
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] e,
                         input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic hang();
        miscompares++;
        $display("Error wait expected done seen timeout");
        complete_run();
    endtask
    // flag in bit 15, clamped code below
    function automatic logic [15:0] code_of(input logic [15:0] p,
                                            input logic [15:0] n);
        logic signed [16:0] d;
        d = {p[15], p} - {n[15], n};
        if (d > 17'sh0_3FFF) return {1'b1, 15'h3FFF};
        if (d < -17'sh0_4000) return {1'b1, 15'h4000};
        return {1'b0, d[14:0]};
    endfunction
    // holds the word until taken; valid stays up for back to back use
    task automatic push(input logic [15:0] p, input logic [15:0] n);
        int k;
        k = 0;
        in_valid = 1'b1;
        in_pos = p;
        in_neg = n;
        while (ready !== 1'b1 && k < 400) begin
            @(posedge clk_sys);
            #1;
            k++;
            stalls++;
        end
        if (k == 400) hang();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic settle(input logic [15:0] e);
        int k;
        k = 0;
        while ({flag, res} !== e && k < 200) begin
            @(posedge clk_smp);
            #1;
            k++;
        end
        if (k == 200) hang();
        // input repeats, so the word must stand and be captured
        repeat (4) @(posedge clk_smp);
        #1;
        check("result word", {1'b0, e[14:0]}, {1'b0, res});
        check("overrange flag", {15'h0000, e[15]}, {15'h0000, flag});
        check("captured word", {1'b0, e[14:0]}, {1'b0, cap_word});
        check("captured flag", {15'h0000, e[15]}, {15'h0000, cap_flag});
    endtask
    task automatic scenario_codes();
        logic [15:0] tp [8] = '{16'h0005, 16'h0000, 16'h3FFF, 16'h4000,
                                16'hC000, 16'hC000, 16'h7FFF, 16'h0000};
        logic [15:0] tn [8] = '{16'h0002, 16'h0001, 16'h0000, 16'h0000,
                                16'h0000, 16'h0001, 16'h8000, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            push(tp[i], tn[i]);
            in_valid = 1'b0;
            settle(code_of(tp[i], tn[i]));
        end
    endtask
    task automatic scenario_strobes();
        int c0;
        @(posedge clk_smp);
        #1;
        c0 = cap_count;
        repeat (10) @(posedge clk_smp);
        #1;
        check("strobe count", 16'h000A, 16'(cap_count - c0));
    endtask
    task automatic scenario_fill();
        stalls = 0;
        for (int i = 1; i <= 12; i++) begin
            push(16'(i * 16), 16'h0000);
        end
        in_valid = 1'b0;
        check("fifo refused", 16'h0001, {15'h0000, stalls > 0});
        settle(code_of(16'h00C0, 16'h0000));
    endtask
    task automatic scenario_pair();
        check("pair fault", 16'h0000, {15'h0000, pair_fault});
        pair_ok = 1'b0;
        repeat (5) @(posedge clk_smp);
        #1;
        check("pair fault", 16'h0001, {15'h0000, pair_fault});
        pair_ok = 1'b1;
        repeat (5) @(posedge clk_smp);
        #1;
        check("pair fault", 16'h0000, {15'h0000, pair_fault});
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        scenario_codes();
        scenario_strobes();
        scenario_fill();
        scenario_pair();
        complete_run();
    end
endmodule
